// ### include/slcr_defines.vh
// Constants for the serial link control register bank
// Notes on behaviour
// - Timestamp enable puts marker on sample LSB
// - Marker latency equals sample path latency
// - Embedded samples keep seven data bits only
// - Advertised control-bit count CS stays zero
// - Enable resets to one; zero holds link reset
// - Disabled link holds multiframe counter in reset
// - Link mode field selects configuration, resets 0x02
// - Only modes allowed by restriction mask accepted
// - Multiframe field holds K minus one, reset 0x1F
// - 64b/66b modes derive K as 256*E/F
// - Writing zero to sync bit requests synchronization
// - Software sync request works for any source select
// - Low selected sync pin requests: pin A at source select 0 or 3, pin B at 1
// - Source select two ignores all sync pins
`ifndef SLCR_DEFINES_VH
`define SLCR_DEFINES_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLCR_ADDR_LSB_CTRL   12'h160
`define SLCR_ADDR_LINK_EN    12'h200
`define SLCR_ADDR_MODE       12'h201
`define SLCR_ADDR_KM1        12'h202
`define SLCR_ADDR_SYNC_REQ   12'h203
`define SLCR_ADDR_SYNC_SEL   12'h204
`define SLCR_ADDR_STATUS     12'h20F
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLCR_RST_LSB_CTRL    1'h0
`define SLCR_RST_LINK_EN     1'h1
`define SLCR_RST_MODE        8'h02
`define SLCR_RST_KM1         8'h1F
`define SLCR_RST_SYNC_REQ    1'h1
`define SLCR_RST_SYNC_SEL    2'h0
`define SLCR_RST_K           9'h020
// ----------------------------------------------------------------
// Field values
// ----------------------------------------------------------------
`define SLCR_SEL_SOFT_ONLY   2'h2
`define SLCR_SEL_PIN_B       2'h1
`define SLCR_CS_ADVERTISED   2'h0
`define SLCR_K64_NUMER       16'h0100
`endif

// ### hdl/slcr_sample_path.v
// Sample path with optional timestamp marker in the LSB
`timescale 1ns/1ps
module slcr_sample_path #(
  parameter WIDTH   = 8,
  parameter LATENCY = 2
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             resetn,
  // Control
  input  wire             embedEnable,
  // Data
  input  wire [WIDTH-1:0] sampleIn,
  input  wire             timestampIn,
  output wire [WIDTH-1:0] sampleOut
);
  // Sample and marker share one delay line so they never drift apart
  reg [WIDTH:0] pipe [0:LATENCY-1];
  integer i;

  // ----------------------------------------------------------------
  // Delay line
  // ----------------------------------------------------------------
  // Marker travels beside its own sample
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (i = 0; i < LATENCY; i = i + 1)
        pipe[i] <= {(WIDTH+1){1'b0}};
    end
    else
    begin
      pipe[0] <= {timestampIn, sampleIn};
      for (i = 1; i < LATENCY; i = i + 1)
        pipe[i] <= pipe[i-1];
    end
  end

  // Marker replaces the LSB, leaving seven data bits
  assign sampleOut = embedEnable ? {pipe[LATENCY-1][WIDTH-1:1], pipe[LATENCY-1][WIDTH]}
                                 : pipe[LATENCY-1][WIDTH-1:0];
endmodule // slcr_sample_path

// ### hdl/slcr_mf_counter.v
// Local multiframe counter aligned by SYSREF
`timescale 1ns/1ps
module slcr_mf_counter (
  // Clock and reset
  input  wire       core_clk,
  input  wire       resetn,
  // Control
  input  wire       hold,
  input  wire [8:0] kFrames,
  input  wire       sysref,
  // Status
  output reg  [8:0] frameCount
);
  // Held at zero while the link is off so SYSREF cannot realign it
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      frameCount <= 9'h000;
    else if (hold)
      frameCount <= 9'h000;
    else if (sysref || frameCount >= kFrames - 9'h001)
      frameCount <= 9'h000;
    else
      frameCount <= frameCount + 9'h001;
  end
endmodule // slcr_mf_counter

// ### hdl/slcr_regs.v
// Serial link control register bank
`timescale 1ns/1ps
`include "slcr_defines.vh"
module slcr_regs #(
  parameter [255:0] MODE_ALLOWED = {256{1'b1}},
  parameter [255:0] MODE_IS_64B  = 256'h0,
  parameter [7:0]   FRAME_E      = 8'h01,
  parameter [7:0]   FRAME_F      = 8'h08,
  parameter         LATENCY      = 2
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       resetn,
  // Register port
  input  wire [11:0] regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdata,
  // Sample stream
  input  wire [7:0]  sampleIn,
  input  wire        timestampIn,
  output reg  [7:0]  sampleOut,
  // Sync and SYSREF
  input  wire        syncPinA_n,
  input  wire        syncPinB_n,
  input  wire        sysref,
  output reg         syncRequest,
  // Link control outputs
  output reg         linkReset,
  output reg         serializerPowerDown,
  output reg         linkClockGate,
  output reg  [7:0]  activeMode,
  output reg  [8:0]  activeK,
  output reg  [1:0]  advertisedCs,
  output reg  [8:0]  mfCount
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg       timestampEmbedEnable;
  reg       linkEnableBit;
  reg [7:0] linkMode;
  reg [7:0] framesPerMultiframeMinusOne;
  reg       softwareSyncRequest;
  reg [1:0] syncSourceSelect;
  reg       modeRejected;

  wire [7:0] pathOut;
  wire [8:0] counterOut;
  wire       pinSync;
  wire       is64b;
  wire [8:0] kDerived;
  reg  [8:0] next_activeK;

  // Derived K for 64b/66b modes
  function [8:0] calcK64;
    input [7:0] e;
    input [7:0] f;
    reg   [15:0] num;
    reg   [15:0] quo;
    begin
      // Divide at full width; slicing first would lose product values of 512 and up
      num = `SLCR_K64_NUMER * {8'h00, e};
      quo = (f == 8'h00) ? 16'h0000 : num / {8'h00, f};
      calcK64 = quo[8:0];
    end
  endfunction

  assign is64b    = MODE_IS_64B[linkMode];
  assign kDerived = calcK64(FRAME_E, FRAME_F);

  // Register writes; rejected modes keep the previous setting
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timestampEmbedEnable        <= `SLCR_RST_LSB_CTRL;
      linkEnableBit               <= `SLCR_RST_LINK_EN;
      linkMode                    <= `SLCR_RST_MODE;
      framesPerMultiframeMinusOne <= `SLCR_RST_KM1;
      softwareSyncRequest         <= `SLCR_RST_SYNC_REQ;
      syncSourceSelect            <= `SLCR_RST_SYNC_SEL;
      modeRejected                <= 1'b0;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `SLCR_ADDR_LSB_CTRL: timestampEmbedEnable <= regWdata[0];
        `SLCR_ADDR_LINK_EN:  linkEnableBit <= regWdata[0];
        `SLCR_ADDR_MODE:
        begin
          if (MODE_ALLOWED[regWdata])
          begin
            linkMode     <= regWdata;
            modeRejected <= 1'b0;
          end
          else
            modeRejected <= 1'b1;
        end
        `SLCR_ADDR_KM1:      framesPerMultiframeMinusOne <= regWdata;
        `SLCR_ADDR_SYNC_REQ: softwareSyncRequest <= regWdata[0];
        `SLCR_ADDR_SYNC_SEL: syncSourceSelect <= regWdata[1:0];
        default:             modeRejected <= modeRejected;
      endcase
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `SLCR_ADDR_LSB_CTRL: regRdata <= {7'h00, timestampEmbedEnable};
        `SLCR_ADDR_LINK_EN:  regRdata <= {7'h00, linkEnableBit};
        `SLCR_ADDR_MODE:     regRdata <= linkMode;
        `SLCR_ADDR_KM1:      regRdata <= framesPerMultiframeMinusOne;
        `SLCR_ADDR_SYNC_REQ: regRdata <= {7'h00, softwareSyncRequest};
        `SLCR_ADDR_SYNC_SEL: regRdata <= {6'h00, syncSourceSelect};
        `SLCR_ADDR_STATUS:   regRdata <= {6'h00, modeRejected, syncRequest};
        default:             regRdata <= 8'h00;
      endcase
    end
    else
      regRdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Link control
  // ----------------------------------------------------------------
  // Pin sync only while a pin source is selected
  assign pinSync = (syncSourceSelect == `SLCR_SEL_SOFT_ONLY) ? 1'b0 :
                   (syncSourceSelect == `SLCR_SEL_PIN_B) ? ~syncPinB_n : ~syncPinA_n;

  always @*
  begin
    next_activeK = is64b ? kDerived : ({1'b0, framesPerMultiframeMinusOne} + 9'h001);
  end

  // Outputs registered; disabled link asserts reset and power-down, drops linkClockGate low and holds the multiframe counter
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      syncRequest         <= 1'b0;
      linkReset           <= 1'b0;
      serializerPowerDown <= 1'b0;
      linkClockGate       <= 1'b1;
      activeMode          <= `SLCR_RST_MODE;
      activeK             <= `SLCR_RST_K;
      advertisedCs        <= `SLCR_CS_ADVERTISED;
      sampleOut           <= 8'h00;
      mfCount             <= 9'h000;
    end
    else
    begin
      syncRequest         <= ~softwareSyncRequest | pinSync;
      linkReset           <= ~linkEnableBit;
      serializerPowerDown <= ~linkEnableBit;
      linkClockGate       <= linkEnableBit;
      activeMode          <= linkMode;
      activeK             <= next_activeK;
      advertisedCs        <= `SLCR_CS_ADVERTISED;
      sampleOut           <= pathOut;
      mfCount             <= counterOut;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  slcr_sample_path #(
    .WIDTH   (8),
    .LATENCY (LATENCY)
  ) u_path (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .embedEnable (timestampEmbedEnable),
    .sampleIn    (sampleIn),
    .timestampIn (timestampIn),
    .sampleOut   (pathOut)
  );

  slcr_mf_counter u_mfc (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .hold       (~linkEnableBit),
    .kFrames    (next_activeK),
    .sysref     (sysref),
    .frameCount (counterOut)
  );
endmodule // slcr_regs

// ### tb/slcr_regs_sva.sv
// Assertion checker for the serial link control register bank
`timescale 1ns/1ps
module slcr_regs_sva #(
  parameter [255:0] MODE_ALLOWED = {256{1'b1}},
  parameter         LATENCY      = 2
) (
  // Clock, reset and register port
  input wire        core_clk,
  input wire        resetn,
  input wire [11:0] regAddr,
  input wire [7:0]  regWdata,
  input wire        regWrite,
  // Stream and sync
  input wire [7:0]  sampleIn,
  input wire [7:0]  sampleOut,
  input wire        syncRequest,
  // Link control
  input wire        linkReset,
  input wire        serializerPowerDown,
  input wire        linkClockGate,
  input wire [7:0]  activeMode,
  input wire [1:0]  advertisedCs,
  input wire [8:0]  mfCount
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // Mode writes, split by the restriction mask
  wire modeWr = regWrite && regAddr == 12'h201;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_cs_zero: assert property (advertisedCs == 2'h0)
    else $error("advertised control count not zero");
  chk_off_outputs: assert property (serializerPowerDown == linkReset && linkClockGate != linkReset)
    else $error("link off outputs disagree");
  chk_enable_write: assert property (regWrite && regAddr == 12'h200 |-> ##2 linkReset == !$past(regWdata[0], 2))
    else $error("link enable write not applied");
  chk_mf_hold: assert property (linkReset && $past(linkReset) |-> mfCount == 9'h000)
    else $error("multiframe counter runs while link off");
  chk_soft_sync: assert property (linkClockGate && regWrite && regAddr == 12'h203 && !regWdata[0] |-> ##2 syncRequest)
    else $error("software sync request lost");
  chk_mode_take: assert property (modeWr && MODE_ALLOWED[regWdata] |-> ##2 activeMode == $past(regWdata, 2))
    else $error("allowed mode not applied");
  chk_mode_refuse: assert property (modeWr && !MODE_ALLOWED[regWdata] |-> ##2 $stable(activeMode))
    else $error("refused mode changed the link");
  chk_data_latency: assert property (sampleOut[7:1] == $past(sampleIn[7:1], LATENCY + 1))
    else $error("sample data latency wrong");
  // Main scenarios reached
  cover property (modeWr && !MODE_ALLOWED[regWdata]);
  cover property (linkReset ##1 !linkReset);
  cover property (syncRequest);
endmodule // slcr_regs_sva

// ### tb/slcr_link_partner.sv
// Receiver-side model that drives the sync pins
`timescale 1ns/1ps
module slcr_link_partner (
  // Bench control
  input  wire holdSyncA,
  input  wire holdSyncB,
  // Sync pins, active low
  output wire syncPinA_n,
  output wire syncPinB_n
);
  // Either pin is held low on request to model a stuck receiver; both idle high
  assign syncPinA_n = ~holdSyncA;
  assign syncPinB_n = ~holdSyncB;
endmodule // slcr_link_partner

// ### tb/slcr_regs_bench.sv
// Self-checking bench for the serial link control register bank
`timescale 1ns/1ps
module slcr_regs_bench;
  reg         core_clk    = 1'b0;
  reg         resetn      = 1'b0;
  reg  [11:0] regAddr     = 12'h000;
  reg  [7:0]  regWdata    = 8'h00;
  reg         regWrite    = 1'b0;
  reg         regRead     = 1'b0;
  reg  [7:0]  sampleIn    = 8'h00;
  reg         timestampIn = 1'b0;
  reg         sysref      = 1'b0;
  reg         holdSyncA   = 1'b0;
  reg         holdSyncB   = 1'b0;
  wire [7:0]  regRdata, sampleOut, activeMode;
  wire [8:0]  activeK, mfCount;
  wire [1:0]  advertisedCs;
  wire        syncPinA_n, syncPinB_n, syncRequest, linkReset, serializerPowerDown, linkClockGate;
  integer     nErrors     = 0;
  integer     nChecks     = 0;
  // Mode 7 refused, mode 5 uses the long code with K = 256*2/8
  slcr_regs #(.MODE_ALLOWED(~256'h80), .MODE_IS_64B(256'h20), .FRAME_E(8'h02), .FRAME_F(8'h08)) slcr_regs_inst (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .sampleIn(sampleIn), .timestampIn(timestampIn),
    .sampleOut(sampleOut), .syncPinA_n(syncPinA_n), .syncPinB_n(syncPinB_n), .sysref(sysref),
    .syncRequest(syncRequest), .linkReset(linkReset), .serializerPowerDown(serializerPowerDown),
    .linkClockGate(linkClockGate), .activeMode(activeMode), .activeK(activeK),
    .advertisedCs(advertisedCs), .mfCount(mfCount));
  slcr_link_partner slcr_link_partner_inst (.holdSyncA(holdSyncA), .holdSyncB(holdSyncB), .syncPinA_n(syncPinA_n),
    .syncPinB_n(syncPinB_n));
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  // Compare and count
  task check(input [8:0] seen, input [8:0] exp);
    begin
      nChecks = nChecks + 1;
      if (seen !== exp)
      begin
        nErrors = nErrors + 1;
        $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One-cycle write strobe
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
    end
  endtask
  // One-cycle read strobe, data looked at in the following cycle only
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 check(regRdata, e);
    end
  endtask
  // Let a write reach the outputs
  task settle;
    begin
      repeat (3) @(posedge core_clk);
      #1;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Watchdog: the sequence needs about 120 cycles
  initial
  begin
    repeat (3000) @(posedge core_clk);
    nErrors = nErrors + 1;
    complete_run;
  end
  // Main sequence; software ordering is kept by the bench itself
  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rd(12'h160, 8'h00);
    rd(12'h200, 8'h01);
    rd(12'h201, 8'h02);
    rd(12'h202, 8'h1F);
    rd(12'h203, 8'h01);
    check(activeK, 9'h020);
    check(advertisedCs, 2'h0);
    wr(12'h200, 8'h00);
    settle;
    check({linkReset, serializerPowerDown, linkClockGate}, 3'h6);
    // A free counter would run on from the pulse; a held one stays at zero
    @(posedge core_clk);
    sysref <= 1'b1;
    @(posedge core_clk);
    sysref <= 1'b0;
    settle;
    check(mfCount, 9'h000);
    wr(12'h202, 8'h0F);
    wr(12'h201, 8'h07);
    settle;
    check(activeK, 9'h010);
    check(activeMode, 8'h02);
    rd(12'h20F, 8'h02);
    wr(12'h201, 8'h05);
    settle;
    check(activeK, 9'h040);
    wr(12'h201, 8'h02);
    settle;
    check(activeK, 9'h010);
    wr(12'h300, 8'h5A);
    rd(12'h300, 8'h00);
    // Marker replaces the data LSB only while embedding; sync receiver enable lives outside this bank
    wr(12'h160, 8'h01);
    @(posedge core_clk);
    sampleIn    <= 8'hA4;
    timestampIn <= 1'b1;
    settle;
    settle;
    check(sampleOut, 8'hA5);
    wr(12'h160, 8'h00);
    settle;
    check(sampleOut, 8'hA4);
    // Sync requests from software and from a stuck pin
    wr(12'h200, 8'h01);
    settle;
    check(syncRequest, 1'b0);
    // Enabled counter restarts on the pulse and then runs
    @(posedge core_clk);
    sysref <= 1'b1;
    @(posedge core_clk);
    sysref <= 1'b0;
    settle;
    check(mfCount, 9'h002);
    wr(12'h203, 8'h00);
    settle;
    check(syncRequest, 1'b1);
    wr(12'h203, 8'h01);
    @(posedge core_clk);
    holdSyncA <= 1'b1;
    settle;
    check(syncRequest, 1'b1);
    wr(12'h204, 8'h02);
    settle;
    check(syncRequest, 1'b0);
    wr(12'h203, 8'h00);
    settle;
    check(syncRequest, 1'b1);
    // Pin B selected: stuck pin A no longer matters, pin B does
    wr(12'h203, 8'h01);
    wr(12'h204, 8'h01);
    rd(12'h204, 8'h01);
    settle;
    check(syncRequest, 1'b0);
    @(posedge core_clk);
    holdSyncB <= 1'b1;
    settle;
    check(syncRequest, 1'b1);
    complete_run;
  end
endmodule // slcr_regs_bench
bind slcr_regs slcr_regs_sva #(.MODE_ALLOWED(MODE_ALLOWED), .LATENCY(LATENCY)) slcr_regs_sva_inst (
  .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .sampleIn(sampleIn), .sampleOut(sampleOut), .syncRequest(syncRequest), .linkReset(linkReset),
  .serializerPowerDown(serializerPowerDown), .linkClockGate(linkClockGate), .activeMode(activeMode),
  .advertisedCs(advertisedCs), .mfCount(mfCount));
